// >>> rtl/ssienc_controller.sv
// controller end: clock master, word receiver, two-entry buffer and wishbone registers
`timescale 1ns/1ns
`include "ssienc_consts.svh"
module ssienc_controller (
	input  wire logic                core_clk_i,
	input  wire logic                reset_i,
	ssienc_link_if.ctrl              link,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o
);
	import ssienc_pkg::*;

	localparam logic [3:0]                 HALF_LAST = 4'(`SSIENC_HALF_CYC - 1);
	localparam logic [`SSIENC_TIMER_W-1:0] TP_CYC = `SSIENC_TIMER_W'(`SSIENC_TP_CYC);
	localparam logic [`SSIENC_FALL_W-1:0]  ONE_END = `SSIENC_FALL_W'(`SSIENC_WORD_BITS + 1);
	localparam logic [`SSIENC_FALL_W-1:0]  SEP_FALL = `SSIENC_FALL_W'(`SSIENC_WORD_BITS + 2);
	localparam logic [`SSIENC_FALL_W-1:0]  RING_END = `SSIENC_FALL_W'(2 * `SSIENC_WORD_BITS + 2);

	ssienc_cstate_type               st_q;
	logic                            clk_q;
	logic [3:0]                      half_q;
	logic [`SSIENC_FALL_W-1:0]       fall_q;
	logic [`SSIENC_TIMER_W-1:0]      pause_q;
	logic                            d1_q;
	logic                            d2_q;
	logic                            d3_q;
	logic                            dlvl_q;
	logic                            lo_seen_q;
	logic                            ring_q;
	logic                            start_q;
	logic                            mism_q;
	ssienc_word_type                 sh_q;
	ssienc_word_type                 first_q;
	ssienc_word_type                 fifo_q [2];
	logic                            wp_q;
	logic                            rp_q;
	logic [1:0]                      cnt_q;
	logic                            launch;
	logic                            tick;
	logic                            frame_end;
	logic                            push;
	logic                            pop;
	logic                            bus_req;
	logic                            wr_fire;
	logic [`SSIENC_FALL_W-1:0]       end_fall;

	// data pin synchroniser; the level counts once stages two and three agree
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			d1_q   <= 1'b1;
			d2_q   <= 1'b1;
			d3_q   <= 1'b1;
			dlvl_q <= 1'b1;
		end else begin
			d1_q <= link.data_p;
			d2_q <= d1_q;
			d3_q <= d2_q;
			if (d2_q == d3_q) begin
				dlvl_q <= d3_q;
			end
		end
	end

	assign end_fall  = ring_q ? RING_END : ONE_END;
	assign tick      = (st_q == SSIENC_C_RUN) && (half_q == HALF_LAST);
	assign frame_end = tick && !clk_q && (fall_q == end_fall);
	// a full buffer holds off the next frame, so a stalled reader loses no word
	assign launch    = (st_q == SSIENC_C_IDLE) && start_q && (cnt_q != 2'd2)
		&& ((dlvl_q && lo_seen_q) || pause_q == '0);
	assign push      = frame_end;

	// data seen low since the last burst; the stale high just after a burst end is no return to rest
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			lo_seen_q <= 1'b1;
		end else if (launch) begin
			lo_seen_q <= 1'b0;
		end else if (st_q == SSIENC_C_IDLE && !dlvl_q) begin
			lo_seen_q <= 1'b1;
		end
	end

	// burst engine: the divider half period stays below the monoflop time
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_q   <= SSIENC_C_IDLE;
			clk_q  <= 1'b1;
			half_q <= '0;
			fall_q <= '0;
		end else if (launch) begin
			st_q   <= SSIENC_C_RUN;
			clk_q  <= 1'b0;
			half_q <= '0;
			fall_q <= `SSIENC_FALL_W'(1);
		end else if (st_q == SSIENC_C_RUN) begin
			half_q <= tick ? '0 : half_q + 1'b1;
			if (tick) begin
				clk_q <= !clk_q;
				if (frame_end) begin
					st_q <= SSIENC_C_IDLE;
				end else if (clk_q) begin
					fall_q <= fall_q + 1'b1;
				end
			end
		end
	end

	// sample on each falling edge after the encoder's rising update edge; skip the low slot
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sh_q    <= '0;
			first_q <= '0;
		end else if (tick && clk_q && fall_q >= `SSIENC_FALL_W'(1) && (fall_q + 1'b1) != SEP_FALL) begin
			sh_q <= {sh_q[`SSIENC_WORD_BITS-2:0], dlvl_q};
		end else if (tick && !clk_q && fall_q == ONE_END) begin
			first_q <= sh_q;
		end
	end

	// pause timer after each burst
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pause_q <= '0;
		end else if (frame_end) begin
			pause_q <= TP_CYC;
		end else if (pause_q != '0) begin
			pause_q <= pause_q - 1'b1;
		end
	end

	// two-entry buffer between the receiver and the data register
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				fifo_q[wp_q] <= (fall_q == ONE_END) ? sh_q : first_q;
				wp_q         <= !wp_q;
			end
			if (pop) begin
				rp_q <= !rp_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// wishbone slave: one wait state, ack for one cycle, unmapped reads give zero
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	assign pop     = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && (wb_adr_i == `SSIENC_REG_DATA)
		&& (cnt_q != 2'd0);

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				unique case (wb_adr_i)
					`SSIENC_REG_CTRL: wb_dat_o <= {30'h0, ring_q, start_q};
					`SSIENC_REG_STAT: wb_dat_o <= {28'h0, mism_q, cnt_q == 2'd2, cnt_q != 2'd0,
						st_q == SSIENC_C_RUN};
					`SSIENC_REG_DATA: wb_dat_o <= (cnt_q != 2'd0) ? {6'h0, fifo_q[rp_q]} : 32'h0;
					default:          wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// control bits; a pending start clears itself when the burst launches
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ring_q  <= 1'b0;
			start_q <= 1'b0;
		end else begin
			if (wr_fire && wb_adr_i == `SSIENC_REG_CTRL) begin
				ring_q <= wb_dat_i[`SSIENC_CTRL_RING];
			end
			if (wr_fire && wb_adr_i == `SSIENC_REG_CTRL && wb_dat_i[`SSIENC_CTRL_START]) begin
				start_q <= 1'b1;
			end else if (launch) begin
				start_q <= 1'b0;
			end
		end
	end

	// repeat mismatch, sticky; a new mismatch wins over a clear in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mism_q <= 1'b0;
		end else if (frame_end && ring_q && sh_q != first_q) begin
			mism_q <= 1'b1;
		end else if (wr_fire && wb_adr_i == `SSIENC_REG_STAT && wb_dat_i[`SSIENC_STAT_MISM]) begin
			mism_q <= 1'b0;
		end
	end

	assign link.clk_p = clk_q;
endmodule

// >>> rtl/ssienc_consts.svh
// constants shared by both ends of the serial position link
`ifndef SSIENC_CONSTS_SVH
`define SSIENC_CONSTS_SVH
`define SSIENC_POS_BITS     25
`define SSIENC_WORD_BITS    26
`define SSIENC_IDX_W        5
`define SSIENC_FALL_W       6
`define SSIENC_CLK_NS       100
`define SSIENC_TM_NS        20000
`define SSIENC_TM_CYC       ((`SSIENC_TM_NS + `SSIENC_CLK_NS - 1) / `SSIENC_CLK_NS)
`define SSIENC_TP_NS        30000
`define SSIENC_TP_CYC       ((`SSIENC_TP_NS + `SSIENC_CLK_NS - 1) / `SSIENC_CLK_NS)
`define SSIENC_HALF_NS      1000
`define SSIENC_HALF_CYC     (`SSIENC_HALF_NS / `SSIENC_CLK_NS)
`define SSIENC_ZERO_NS      1100000000
`define SSIENC_ZERO_CYC     ((`SSIENC_ZERO_NS + `SSIENC_CLK_NS - 1) / `SSIENC_CLK_NS)
`define SSIENC_TIMER_W      16
`define SSIENC_ZERO_W       24
`define SSIENC_PIN_RST      3'b101
`define SSIENC_REG_CTRL     8'h00
`define SSIENC_REG_STAT     8'h04
`define SSIENC_REG_DATA     8'h08
`define SSIENC_CTRL_START   0
`define SSIENC_CTRL_RING    1
`define SSIENC_STAT_BUSY    0
`define SSIENC_STAT_AVAIL   1
`define SSIENC_STAT_FULL    2
`define SSIENC_STAT_MISM    3
`endif

// >>> rtl/ssienc_pkg.sv
// types shared by both ends of the serial position link
package ssienc_pkg;
	typedef logic [24:0] ssienc_pos_type;
	typedef logic [25:0] ssienc_word_type;
	typedef enum logic {SSIENC_C_IDLE, SSIENC_C_RUN} ssienc_cstate_type;
endpackage

// >>> rtl/ssienc_link_if.sv
// positive clock and data lines between controller and encoder
`timescale 1ns/1ns
interface ssienc_link_if;
	logic clk_p;
	logic data_p;
	modport ctrl (output clk_p, input data_p);
	modport enc  (input clk_p, output data_p);
endinterface

// >>> rtl/ssienc_encoder.sv
// encoder end: position counter, zero-set, direction select and serial word output
//
// Behaviour
// - controller bursts clock, encoder answers with data
// - clock and data rest high when idle
// - first falling edge latches position and status
// - first rising edge presents the MSB
// - each later rising edge presents next bit
// - after LSB data low until timeout
// - every falling edge restarts the monoflop timeout
// - controller waits for data high or pause
// - controller keeps edge gaps below the timeout
// - each word carries exactly the fixed bit count
// - unbroken clocking resends the same latched word
// - pulse n+1 within timeout repeats the word
// - late pulse n+1 latches a fresh position
// - word coded gray or binary as configured
// - direction pin high makes clockwise count down
// - zero-set falling edge clears the position
// - zero-set must stay low the minimum time
`timescale 1ns/1ns
`include "ssienc_consts.svh"
module ssienc_encoder #(
	parameter int unsigned ZERO_HOLD_CYC = `SSIENC_ZERO_CYC
) (
	input  wire logic                core_clk_i,
	input  wire logic                reset_i,
	ssienc_link_if.enc               link,
	input  wire logic                rot_step_i,
	input  wire logic                rot_cw_i,
	input  wire logic                dir_sel_i,
	input  wire logic                zero_set_n_i,
	input  wire logic                gray_sel_i,
	input  wire logic                status_bit_i,
	output logic [24:0]              position_o,
	output logic                     frame_active_o
);
	import ssienc_pkg::*;

	localparam logic [`SSIENC_TIMER_W-1:0] TM_CYC = `SSIENC_TIMER_W'(`SSIENC_TM_CYC);
	localparam logic [`SSIENC_IDX_W-1:0]   LAST_IDX = `SSIENC_IDX_W'(`SSIENC_WORD_BITS);
	localparam logic [`SSIENC_ZERO_W-1:0]  ZERO_LAST = `SSIENC_ZERO_W'(ZERO_HOLD_CYC - 1);
	localparam logic [2:0]                 PIN_RST = `SSIENC_PIN_RST;

	// pin order: 0 link clock, 1 direction select, 2 zero-set
	logic [2:0]                      pin_in;
	logic [2:0]                      sync1_q;
	logic [2:0]                      sync2_q;
	logic [2:0]                      sync3_q;
	logic [2:0]                      lvl_q;
	logic [2:0]                      agree;
	logic                            ck_fall;
	logic                            ck_rise;
	logic                            zero_fall;
	logic                            zero_fire;
	logic                            zero_wait_q;
	logic [`SSIENC_ZERO_W-1:0]       zero_cnt_q;
	logic [`SSIENC_TIMER_W-1:0]      mono_q;
	logic                            busy_q;
	logic                            expire;
	ssienc_pos_type                  pos_q;
	ssienc_word_type                 word_q;
	logic [`SSIENC_IDX_W-1:0]        idx_q;
	logic                            data_q;

	// plain binary to reflected gray
	function automatic ssienc_pos_type to_gray(input ssienc_pos_type b);
		to_gray = b ^ (b >> 1);
	endfunction

	assign pin_in = {zero_set_n_i, dir_sel_i, link.clk_p};

	// three-stage synchroniser per pin; a level counts only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			assign agree[g] = (sync2_q[g] == sync3_q[g]);
			always_ff @(posedge core_clk_i) begin
				if (reset_i) begin
					sync1_q[g] <= PIN_RST[g];
					sync2_q[g] <= PIN_RST[g];
					sync3_q[g] <= PIN_RST[g];
					lvl_q[g]   <= PIN_RST[g];
				end else begin
					sync1_q[g] <= pin_in[g];
					sync2_q[g] <= sync1_q[g];
					sync3_q[g] <= sync2_q[g];
					if (agree[g]) begin
						lvl_q[g] <= sync3_q[g];
					end
				end
			end
		end
	endgenerate

	// edges of the filtered link clock and zero-set pin
	assign ck_fall   = agree[0] && !sync3_q[0] && lvl_q[0];
	assign ck_rise   = agree[0] && sync3_q[0] && !lvl_q[0];
	assign zero_fall = agree[2] && !sync3_q[2] && lvl_q[2];

	// monoflop: reloaded on every falling edge, so the last one of a burst times the pause
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mono_q <= '0;
		end else if (ck_fall) begin
			mono_q <= TM_CYC;
		end else if (mono_q != '0) begin
			mono_q <= mono_q - 1'b1;
		end
	end

	assign expire = busy_q && !ck_fall && (mono_q == `SSIENC_TIMER_W'(1));

	// frame state: opened by the first falling edge, closed only by the monoflop
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			busy_q <= 1'b0;
		end else if (ck_fall && !busy_q) begin
			busy_q <= 1'b1;
		end else if (expire) begin
			busy_q <= 1'b0;
		end
	end

	// word latched once per frame; a late pulse n+1 finds the frame closed and relatches
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			word_q <= '0;
		end else if (ck_fall && !busy_q) begin
			word_q <= {(gray_sel_i ? to_gray(pos_q) : pos_q), status_bit_i};
		end
	end

	// bit pointer: counts rising edges, wraps after the low slot so the same word comes again
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			idx_q <= '0;
		end else if (ck_fall && !busy_q) begin
			idx_q <= '0;
		end else if (ck_rise && busy_q) begin
			if (idx_q == LAST_IDX) begin
				idx_q <= '0;
			end else begin
				idx_q <= idx_q + 1'b1;
			end
		end
	end

	// data line: high at rest, MSB first, low after the LSB until the monoflop runs out
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			data_q <= 1'b1;
		end else if (ck_rise && busy_q) begin
			if (idx_q == LAST_IDX) begin
				data_q <= 1'b0;
			end else begin
				data_q <= word_q[`SSIENC_WORD_BITS - 1 - int'(idx_q)];
			end
		end else if (expire) begin
			data_q <= 1'b1;
		end
	end

	// zero-set: armed by a falling edge, fires only if the pin stays low the full hold time
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			zero_wait_q <= 1'b0;
			zero_cnt_q  <= '0;
		end else if (zero_fall) begin
			zero_wait_q <= 1'b1;
			zero_cnt_q  <= '0;
		end else if (zero_wait_q) begin
			if (lvl_q[2] || zero_fire) begin
				zero_wait_q <= 1'b0;
			end
			zero_cnt_q <= zero_cnt_q + 1'b1;
		end
	end

	assign zero_fire = zero_wait_q && !lvl_q[2] && (zero_cnt_q == ZERO_LAST);

	// position counter; zero-set wins over a step in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pos_q <= '0;
		end else if (zero_fire) begin
			pos_q <= '0;
		end else if (rot_step_i) begin
			if (rot_cw_i ^ lvl_q[1]) begin
				pos_q <= pos_q + 1'b1;
			end else begin
				pos_q <= pos_q - 1'b1;
			end
		end
	end

	// user-side outputs, all flopped
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			position_o     <= '0;
			frame_active_o <= 1'b0;
		end else begin
			position_o     <= pos_q;
			frame_active_o <= busy_q;
		end
	end

	assign link.data_p = data_q;
endmodule

// >>> sim/ssienc_link_monitor.sv
// checker for the serial clock and data lines between controller and encoder
`timescale 1ns/1ns
module ssienc_link_monitor (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic clk_p,
	input  wire logic data_p
);
	logic [7:0] hi_cnt_q;
	logic [5:0] fall_cnt_q;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// cycles the clock has stood high; reset reads as long idle so no burst end is faked
	always_ff @(posedge core_clk_i) begin
		if (reset_i || (clk_p && hi_cnt_q == 8'hff)) hi_cnt_q <= 8'hff;
		else if (!clk_p) hi_cnt_q <= 8'h00;
		else hi_cnt_q <= hi_cnt_q + 8'h01;
	end
	// falls within one burst; a fall after a long high spell opens a new count
	always_ff @(posedge core_clk_i) begin
		if (reset_i) fall_cnt_q <= 6'h00;
		else if (!clk_p && hi_cnt_q > 8'h0b) fall_cnt_q <= 6'h01;
		else if (!clk_p && hi_cnt_q != 8'h00) fall_cnt_q <= fall_cnt_q + 6'h01;
	end
	reset_idle_a: assert property ($fell(reset_i) |-> clk_p && data_p)
		else $error("lines not idle high after reset");
	idle_level_a: assert property (hi_cnt_q == 8'hff |-> data_p)
		else $error("data not high in idle");
	half_period_a: assert property ($fell(clk_p) |=> !clk_p [*8] ##1 !clk_p ##1 clk_p)
		else $error("clock low phase not ten cycles");
	data_update_a: assert property ($changed(data_p) |-> clk_p)
		else $error("data changed while clock low");
	data_rise_time_a: assert property ($rose(data_p) |->
		hi_cnt_q <= 8'h06 || (hi_cnt_q >= 8'hb9 && hi_cnt_q <= 8'hcd))
		else $error("data rose outside update or timeout window");
	lsb_low_hold_a: assert property (clk_p && hi_cnt_q >= 8'h0c && hi_cnt_q <= 8'hb4 |-> !data_p)
		else $error("data not low before timeout");
	word_count_a: assert property (hi_cnt_q == 8'h0b |->
		fall_cnt_q == 6'h1b || fall_cnt_q == 6'h36)
		else $error("burst length wrong");
	start_gap_a: assert property (!clk_p && hi_cnt_q > 8'h0b |-> data_p)
		else $error("burst started while data low");
	cover property (!clk_p && hi_cnt_q > 8'h0b);
	cover property (hi_cnt_q == 8'h0b && fall_cnt_q == 6'h36);
	cover property ($rose(data_p) && hi_cnt_q > 8'h64);
endmodule

// >>> sim/ssi_position_encoder_port_test.sv
// testbench: both link ends joined, driven through wishbone and the encoder pins
`timescale 1ns/1ns
`include "ssienc_consts.svh"
module ssi_position_encoder_port_test;
	logic        clk;
	logic        rst;
	logic        step;
	logic        cw;
	logic        dir_sel;
	logic        zero_n;
	logic        gray;
	logic        status;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdo;
	logic [31:0] rdat;
	logic [31:0] tmp;
	logic        ack;
	logic [24:0] pos;
	logic        active;
	int          num_errors;
	int          cmp_count;
	int          cycles;
	ssienc_link_if link();
	ssienc_encoder #(.ZERO_HOLD_CYC(20)) i_ssienc_encoder (.core_clk_i(clk), .reset_i(rst), .link(link),
		.rot_step_i(step), .rot_cw_i(cw), .dir_sel_i(dir_sel), .zero_set_n_i(zero_n), .gray_sel_i(gray),
		.status_bit_i(status), .position_o(pos), .frame_active_o(active));
	ssienc_controller i_ssienc_controller (.core_clk_i(clk), .reset_i(rst), .link(link), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo),
		.wb_ack_o(ack));
	ssienc_link_monitor i_ssienc_link_monitor (.core_clk_i(clk), .reset_i(rst), .clk_p(link.clk_p),
		.data_p(link.data_p));
	// 100 ns clock
	always #50 clk = ~clk;
	// hang guard: the whole sequence needs under a tenth of this
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			finish_test();
		end
	end
	task finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one classic cycle; ack and read data are taken at the rising edge, the request drops at that edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rdat = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(n, e, rdat);
	endtask
	task steps(input logic c, input int k);
		repeat (k) begin
			@(posedge clk);
			step <= 1'b1;
			cw <= c;
			@(posedge clk);
			step <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask
	// polls until no start is pending and the link is not busy
	task wait_idle();
		int i;
		for (i = 0; i < 1000; i++) begin
			wb(1'b0, `SSIENC_REG_CTRL, 32'h0);
			tmp = rdat;
			wb(1'b0, `SSIENC_REG_STAT, 32'h0);
			if (tmp[0] === 1'b0 && rdat[0] === 1'b0) break;
		end
	endtask
	initial begin
		clk = 1'b0;
		cycles = 0;
		num_errors = 0;
		cmp_count = 0;
		rst = 1'b1;
		step = 1'b0;
		cw = 1'b1;
		dir_sel = 1'b0;
		zero_n = 1'b1;
		gray = 1'b0;
		status = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		check("idle lines", 32'h3, {30'h0, link.clk_p, link.data_p});
		rd_chk("stat reset", `SSIENC_REG_STAT, 32'h0);
		rd_chk("data empty", `SSIENC_REG_DATA, 32'h0);
		rd_chk("unmapped", 8'h0c, 32'h0);
		// a write with the low byte lane off must not start anything
		sel <= 4'he;
		wb(1'b1, `SSIENC_REG_CTRL, 32'h3);
		sel <= 4'hf;
		rd_chk("masked write", `SSIENC_REG_CTRL, 32'h0);
		$display("test reset done");
		steps(1'b1, 5);
		check("count up", 32'h5, {7'h0, pos});
		dir_sel <= 1'b1;
		repeat (6) @(posedge clk);
		steps(1'b1, 2);
		check("count down", 32'h3, {7'h0, pos});
		$display("test direction done");
		// two words stacked unread: binary with status set, then gray
		wb(1'b1, `SSIENC_REG_CTRL, 32'h1);
		wait_idle();
		gray <= 1'b1;
		status <= 1'b0;
		steps(1'b0, 1);
		wb(1'b1, `SSIENC_REG_CTRL, 32'h1);
		wait_idle();
		rd_chk("stat full", `SSIENC_REG_STAT, 32'h6);
		rd_chk("binary word", `SSIENC_REG_DATA, 32'h7);
		rd_chk("gray word", `SSIENC_REG_DATA, 32'hc);
		rd_chk("stat drained", `SSIENC_REG_STAT, 32'h0);
		$display("test words done");
		// position moves mid-frame: the repeat must still carry the latched word
		gray <= 1'b0;
		wb(1'b1, `SSIENC_REG_CTRL, 32'h3);
		repeat (300) @(posedge clk);
		check("frame active", 32'h1, {31'h0, active});
		steps(1'b1, 2);
		wait_idle();
		rd_chk("ring ctrl", `SSIENC_REG_CTRL, 32'h2);
		rd_chk("ring stat", `SSIENC_REG_STAT, 32'h2);
		rd_chk("ring word", `SSIENC_REG_DATA, 32'h8);
		wb(1'b1, `SSIENC_REG_CTRL, 32'h1);
		wait_idle();
		rd_chk("fresh word", `SSIENC_REG_DATA, 32'h4);
		$display("test ring done");
		// a low spell shorter than the hold time leaves the position alone
		zero_n <= 1'b0;
		repeat (10) @(posedge clk);
		zero_n <= 1'b1;
		repeat (30) @(posedge clk);
		check("short zero", 32'h2, {7'h0, pos});
		zero_n <= 1'b0;
		repeat (30) @(posedge clk);
		zero_n <= 1'b1;
		repeat (5) @(posedge clk);
		check("zero set", 32'h0, {7'h0, pos});
		$display("test zero done");
		finish_test();
	end
endmodule
